/* File: logic/frame_consts.svh */
// named constants for the request frame decoder
`ifndef FRAME_CONSTS_SVH
`define FRAME_CONSTS_SVH

`define START_DELIM     8'h7E
`define CSUM_GOOD       8'hFF
`define TYPE_AT_NOW     8'h08
`define TYPE_AT_QUEUED  8'h09
`define TYPE_TX_REQ     8'h10
`define TYPE_AT_RESP    8'h88
`define TYPE_TX_STATUS  8'h8B
`define FRAME_ID_NONE   8'h00
`define VALUE_NONE      8'h00
`define USE_DEFAULT     8'h00

// body indices count from the frame-type byte (frame offset minus three)
`define IDX_TYPE        16'h0000
`define IDX_FID         16'h0001
`define IDX_CMD_HI      16'h0002
`define IDX_CMD_LO      16'h0003
`define IDX_PARAM       16'h0004
`define IDX_DEST16_HI   16'h000A
`define IDX_DEST16_LO   16'h000B
`define IDX_RADIUS      16'h000C
`define IDX_OPTIONS     16'h000D
`define IDX_PAYLOAD     16'h000E
`define LEN_EMPTY       16'h0000
`define ONE16           16'h0001

`define CMD_APPLY       16'h4143
`define CMD_BAUD_RATE   16'h4244
`define CMD_MAX_HOPS    16'h4E48
`define CMD_TX_OPTIONS  16'h544F
`define CMD_MAX_PAYLOAD 16'h4E50

`define MASK_NONE       3'h0
`define MASK_BAUD       3'h1
`define MASK_HOPS       3'h2
`define MASK_TXOPT      3'h4

`define RST_BAUD_RATE   8'h03
`define RST_MAX_HOPS    8'h07
`define RST_TX_OPTIONS  8'h00
`define RST_MAX_PAYLOAD 8'h64

`define ADDR_CONTROL    8'h00
`define ADDR_ACTIVE     8'h04
`define ADDR_STAGED     8'h08
`define ADDR_MAXPAY     8'h0C
`define ADDR_DROPS      8'h10
`define REG_CONTROL     3'h0
`define REG_ACTIVE      3'h1
`define REG_STAGED      3'h2
`define REG_MAXPAY      3'h3
`define REG_DROPS       3'h4
`define REG_NONE        3'h7

`define FIFO_WIDTH      8
`define FIFO_DEPTH      16
`define FIFO_LAST       5'h0F

`endif

/* File: logic/frame_pkg.sv */
// shared types for the request frame decoder
package frame_pkg;

  typedef enum logic [4:0] {
    PH_HUNT   = 5'b00001,
    PH_LEN_HI = 5'b00010,
    PH_LEN_LO = 5'b00100,
    PH_BODY   = 5'b01000,
    PH_CSUM   = 5'b10000
  } parse_state_type;

  typedef struct packed {
    logic [7:0]  frame_type;
    logic [7:0]  frame_id;
    logic [15:0] command;
    logic [7:0]  value;
  } response_type;

  typedef struct packed {
    logic [7:0]  frame_id;
    logic [63:0] dest64;
    logic [15:0] dest16;
    logic [7:0]  radius;
    logic [7:0]  options;
  } tx_request_type;

  typedef struct packed {
    logic [7:0] max_payload;
    logic [7:0] tx_options;
    logic [7:0] max_hops;
    logic [7:0] baud_rate;
  } settings_type;

  typedef struct packed {
    parse_state_type phase;
    logic [15:0]     len;
    logic [15:0]     idx;
    logic [7:0]      sum;
    logic [7:0]      ftype;
    logic [7:0]      fid;
    logic [15:0]     cmd;
    logic [7:0]      val;
    logic            has_val;
    logic            bad;
    logic [63:0]     dest64;
    logic [15:0]     dest16;
    logic [7:0]      radius;
    logic [7:0]      opts;
    logic [15:0]     paycnt;
    settings_type    active;
    settings_type    staged;
    logic [2:0]      pend;
    logic            enable;
    logic [15:0]     drops;
    logic            rx_ready;
    logic            resp_valid;
    response_type    resp;
    logic            tx_valid;
    tx_request_type  tx;
    logic [31:0]     prdata;
    logic            pready;
    logic            pslverr;
  } decoder_state_type;

endpackage : frame_pkg

/* File: logic/payload_fifo.sv */
// payload byte fifo whose written bytes become visible only on commit
`timescale 1ns/10ps
module payload_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     commit,
  input  wire logic                     drop,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic [$clog2(DEPTH):0]        occupancy
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW:0]                 wr;
    logic [PW:0]                 cm;
    logic [PW:0]                 rd;
    logic                        out_valid;
    logic [WIDTH-1:0]            out_data;
  } fifo_state_type;

  fifo_state_type state;
  fifo_state_type next_state;
  logic [PW:0]    used;

  assign used      = state.wr - state.rd;
  assign in_ready  = (used != (PW+1)'(DEPTH));
  assign occupancy = used;
  assign out_valid = state.out_valid;
  assign out_data  = state.out_data;

  always_comb begin
    next_state = state;
    if (state.out_valid && out_ready) begin
      next_state.out_valid = 1'b0;
    end
    // only committed words move to the output stage
    if ((!state.out_valid || out_ready) && state.rd != state.cm) begin
      next_state.out_data  = state.mem[state.rd[PW-1:0]];
      next_state.out_valid = 1'b1;
      next_state.rd        = state.rd + 1'b1;
    end
    if (in_valid && in_ready && !drop) begin
      next_state.mem[state.wr[PW-1:0]] = in_data;
      next_state.wr                    = state.wr + 1'b1;
    end
    if (drop) begin
      next_state.wr = state.cm;
    end else if (commit) begin
      next_state.cm = next_state.wr;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

endmodule : payload_fifo

/* File: logic/api_request_frame_decoder.sv */
// request frame decoder: queued local commands, transmit requests, apb settings access
`timescale 1ns/10ps
`include "frame_consts.svh"
// How it works
// [RULE_01] frame opens with start delimiter, then 16-bit length of the body bytes
// [RULE_02] last byte is checksum: 0xFF minus low byte of body sum
// [RULE_03] body byte zero is frame type; 0x09 selects queued local command path
// [RULE_04] next byte is frame id, echoed in replies; zero suppresses any reply
// [RULE_05] queued command carries a two-character 16-bit command code
// [RULE_06] optional value follows command; none means query current value
// [RULE_07] queued writes are staged until an immediate frame or apply command
// [RULE_08] query answer is type 0x88 with current value and same frame id
// [RULE_09] a queued baud change keeps the old rate until applied
// [RULE_10] type 0x10 is a transmit request, answered by 0x8B status unless id zero
// [RULE_11] transmit request carries 64-bit destination, unicast or broadcast pattern
// [RULE_12] host fills 64-bit destination with ones for short addressing
// [RULE_13] 16-bit destination holds short address or 0xFFFE
// [RULE_14] broadcast radius zero means use configured max hops
// [RULE_15] transmit options zero means use stored default options
// [RULE_16] payload runs to checksum and may not exceed the maximum payload
// [RULE_17] an immediate local command write takes effect at once
// [RULE_18] bad checksum or length drops frame silently; hunt next delimiter
module api_request_frame_decoder (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic [7:0]               rx_data,
  input  wire logic                     rx_valid,
  output logic                          rx_ready,
  output logic                          resp_valid,
  output frame_pkg::response_type       resp,
  output logic                          tx_valid,
  output frame_pkg::tx_request_type     tx_req,
  output logic [7:0]                    pay_data,
  output logic                          pay_valid,
  input  wire logic                     pay_ready,
  output logic [7:0]                    baud_sel,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr
);
  import frame_pkg::*;

  decoder_state_type state;
  decoder_state_type next_state;
  logic              rx_take;
  logic              is_at;
  logic              is_tx;
  logic              short_frame;
  logic              frame_end;
  logic              frame_ok;
  logic              pay_room;
  logic              pay_push;
  logic              fifo_in_ready;
  logic              frame_commit;
  logic              frame_drop;
  logic [4:0]        fifo_occ;

  function automatic logic [2:0] reg_index(input logic [7:0] addr);
    case (addr)
      `ADDR_CONTROL: reg_index = `REG_CONTROL;
      `ADDR_ACTIVE:  reg_index = `REG_ACTIVE;
      `ADDR_STAGED:  reg_index = `REG_STAGED;
      `ADDR_MAXPAY:  reg_index = `REG_MAXPAY;
      `ADDR_DROPS:   reg_index = `REG_DROPS;
      default:       reg_index = `REG_NONE;
    endcase
  endfunction : reg_index

  function automatic logic [2:0] setting_mask(input logic [15:0] cmd);
    case (cmd)
      `CMD_BAUD_RATE:  setting_mask = `MASK_BAUD;
      `CMD_MAX_HOPS:   setting_mask = `MASK_HOPS;
      `CMD_TX_OPTIONS: setting_mask = `MASK_TXOPT;
      default:         setting_mask = `MASK_NONE;
    endcase
  endfunction : setting_mask

  function automatic settings_type setting_update(input settings_type s, input logic [2:0] mask,
                                                  input logic [7:0] val);
    setting_update = s;
    if ((mask & `MASK_BAUD) != `MASK_NONE) begin
      setting_update.baud_rate = val;
    end
    if ((mask & `MASK_HOPS) != `MASK_NONE) begin
      setting_update.max_hops = val;
    end
    if ((mask & `MASK_TXOPT) != `MASK_NONE) begin
      setting_update.tx_options = val;
    end
  endfunction : setting_update

  function automatic settings_type apply_pending(input settings_type act, input settings_type stg,
                                                 input logic [2:0] pend);
    apply_pending = setting_update(act, pend & `MASK_BAUD, stg.baud_rate);
    apply_pending = setting_update(apply_pending, pend & `MASK_HOPS, stg.max_hops);
    apply_pending = setting_update(apply_pending, pend & `MASK_TXOPT, stg.tx_options);
  endfunction : apply_pending

  function automatic logic [7:0] setting_value(input settings_type s, input logic [15:0] cmd);
    case (cmd)
      `CMD_BAUD_RATE:   setting_value = s.baud_rate;
      `CMD_MAX_HOPS:    setting_value = s.max_hops;
      `CMD_TX_OPTIONS:  setting_value = s.tx_options;
      `CMD_MAX_PAYLOAD: setting_value = s.max_payload;
      default:          setting_value = `VALUE_NONE;
    endcase
  endfunction : setting_value

  assign rx_take      = rx_valid && state.rx_ready;
  assign is_at        = (state.ftype == `TYPE_AT_NOW) || (state.ftype == `TYPE_AT_QUEUED); // [RULE_03]
  assign is_tx        = (state.ftype == `TYPE_TX_REQ); // [RULE_10]
  assign short_frame  = (is_at && state.len < `IDX_PARAM) || (is_tx && state.len < `IDX_PAYLOAD); // [RULE_18]
  assign frame_end    = rx_take && state.phase == PH_CSUM;
  assign frame_ok     = frame_end && !state.bad && !short_frame
                        && (8'(state.sum + rx_data) == `CSUM_GOOD); // [RULE_02]
  assign pay_room     = state.paycnt < {8'h00, state.active.max_payload}; // [RULE_16]
  assign pay_push     = rx_take && state.phase == PH_BODY && is_tx && state.idx >= `IDX_PAYLOAD
                        && pay_room && !state.bad && fifo_in_ready;
  assign frame_commit = frame_ok && is_tx;
  assign frame_drop   = frame_end && !frame_commit; // [RULE_18]

  payload_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH)
  ) payload_buffer (
    .clock     (clock),
    .rst       (rst),
    .in_valid  (pay_push),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_data),
    .commit    (frame_commit),
    .drop      (frame_drop),
    .out_valid (pay_valid),
    .out_ready (pay_ready),
    .out_data  (pay_data),
    .occupancy (fifo_occ)
  );

  always_comb begin
    next_state            = state;
    next_state.resp_valid = 1'b0;
    next_state.tx_valid   = 1'b0;
    next_state.pready     = 1'b0;
    // byte intake stalls before the payload buffer can overflow
    next_state.rx_ready   = (5'(fifo_occ + {4'h0, pay_push}) <= `FIFO_LAST);

    if (psel && penable && !state.pready) begin
      next_state.pready  = 1'b1;
      next_state.pslverr = (reg_index(paddr) == `REG_NONE);
      case (reg_index(paddr))
        `REG_CONTROL: next_state.prdata = {31'h00000000, state.enable};
        `REG_ACTIVE:  next_state.prdata = {8'h00, state.active.tx_options, state.active.max_hops,
                                           state.active.baud_rate};
        `REG_STAGED:  next_state.prdata = {5'h00, state.pend, state.staged.tx_options,
                                           state.staged.max_hops, state.staged.baud_rate};
        `REG_MAXPAY:  next_state.prdata = {24'h000000, state.active.max_payload};
        `REG_DROPS:   next_state.prdata = {16'h0000, state.drops};
        default:      next_state.prdata = 32'h00000000;
      endcase
    end
    if (psel && penable && state.pready && pwrite) begin
      case (reg_index(paddr))
        `REG_CONTROL: next_state.enable = pwdata[0];
        `REG_MAXPAY:  next_state.active.max_payload = pwdata[7:0];
        `REG_DROPS:   next_state.drops = 16'h0000;
        default:      next_state.enable = state.enable;
      endcase
    end

    if (rx_take) begin
      case (state.phase)
        PH_HUNT: begin
          if (rx_data == `START_DELIM && state.enable) begin // [RULE_01]
            next_state.phase = PH_LEN_HI;
          end
        end
        PH_LEN_HI: begin
          next_state.len   = {rx_data, 8'h00}; // [RULE_01]
          next_state.phase = PH_LEN_LO;
        end
        PH_LEN_LO: begin
          next_state.len     = {state.len[15:8], rx_data};
          next_state.idx     = `LEN_EMPTY;
          next_state.sum     = 8'h00;
          next_state.bad     = 1'b0;
          next_state.has_val = 1'b0;
          next_state.paycnt  = 16'h0000;
          next_state.ftype   = 8'h00;
          next_state.phase   = ({state.len[15:8], rx_data} == `LEN_EMPTY) ? PH_HUNT : PH_BODY;
        end
        PH_BODY: begin
          next_state.sum = 8'(state.sum + rx_data); // [RULE_02]
          next_state.idx = 16'(state.idx + `ONE16);
          if (16'(state.idx + `ONE16) == state.len) begin
            next_state.phase = PH_CSUM;
          end
          if (state.idx == `IDX_TYPE) begin
            next_state.ftype = rx_data; // [RULE_03]
          end else if (state.idx == `IDX_FID) begin
            next_state.fid = rx_data; // [RULE_04]
          end else if (is_at) begin
            if (state.idx == `IDX_CMD_HI) begin
              next_state.cmd[15:8] = rx_data; // [RULE_05]
            end else if (state.idx == `IDX_CMD_LO) begin
              next_state.cmd[7:0] = rx_data; // [RULE_05]
            end else begin
              // multi-byte values keep their last byte
              next_state.val     = rx_data; // [RULE_06]
              next_state.has_val = 1'b1;
            end
          end else if (is_tx) begin
            if (state.idx < `IDX_DEST16_HI) begin
              next_state.dest64 = {state.dest64[55:0], rx_data}; // [RULE_11] [RULE_12]
            end else if (state.idx == `IDX_DEST16_HI) begin
              next_state.dest16[15:8] = rx_data; // [RULE_13]
            end else if (state.idx == `IDX_DEST16_LO) begin
              next_state.dest16[7:0] = rx_data;
            end else if (state.idx == `IDX_RADIUS) begin
              next_state.radius = rx_data;
            end else if (state.idx == `IDX_OPTIONS) begin
              next_state.opts = rx_data;
            end else begin
              next_state.paycnt = 16'(state.paycnt + `ONE16);
              if (!pay_room) begin
                next_state.bad = 1'b1; // [RULE_16]
              end
            end
          end
        end
        PH_CSUM: begin
          next_state.phase = PH_HUNT; // [RULE_18]
        end
        default: begin
          next_state.phase = PH_HUNT;
        end
      endcase
    end

    if (frame_ok && is_at) begin
      if (state.ftype == `TYPE_AT_NOW || state.cmd == `CMD_APPLY) begin
        next_state.active = apply_pending(next_state.active, state.staged, state.pend); // [RULE_07] [RULE_09]
        next_state.pend   = `MASK_NONE;
      end
      if (state.has_val && state.ftype == `TYPE_AT_NOW) begin
        next_state.active = setting_update(next_state.active, setting_mask(state.cmd), state.val); // [RULE_17]
      end else if (state.has_val) begin
        next_state.staged = setting_update(state.staged, setting_mask(state.cmd), state.val); // [RULE_07]
        next_state.pend   = next_state.pend | setting_mask(state.cmd);
      end
      if (state.fid != `FRAME_ID_NONE) begin // [RULE_04]
        next_state.resp_valid       = 1'b1;
        next_state.resp.frame_type  = `TYPE_AT_RESP; // [RULE_08]
        next_state.resp.frame_id    = state.fid;
        next_state.resp.command     = state.cmd;
        next_state.resp.value       = state.has_val ? `VALUE_NONE
                                      : setting_value(state.active, state.cmd); // [RULE_06] [RULE_08]
      end
    end else if (frame_ok && is_tx) begin
      next_state.tx_valid    = 1'b1;
      next_state.tx.frame_id = state.fid;
      next_state.tx.dest64   = state.dest64; // [RULE_11]
      next_state.tx.dest16   = state.dest16;
      next_state.tx.radius   = (state.radius == `USE_DEFAULT) ? state.active.max_hops : state.radius; // [RULE_14]
      next_state.tx.options  = (state.opts == `USE_DEFAULT) ? state.active.tx_options : state.opts; // [RULE_15]
      if (state.fid != `FRAME_ID_NONE) begin // [RULE_04]
        next_state.resp_valid      = 1'b1;
        next_state.resp.frame_type = `TYPE_TX_STATUS; // [RULE_10]
        next_state.resp.frame_id   = state.fid;
        next_state.resp.command    = 16'h0000;
        next_state.resp.value      = `VALUE_NONE;
      end
    end else if (frame_end && !frame_ok) begin
      next_state.drops = 16'(next_state.drops + `ONE16); // [RULE_18]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state                    <= '0;
      state.phase              <= PH_HUNT;
      state.active.baud_rate   <= `RST_BAUD_RATE;
      state.active.max_hops    <= `RST_MAX_HOPS;
      state.active.tx_options  <= `RST_TX_OPTIONS;
      state.active.max_payload <= `RST_MAX_PAYLOAD;
      state.enable             <= 1'b1;
      state.rx_ready           <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign rx_ready   = state.rx_ready;
  assign resp_valid = state.resp_valid;
  assign resp       = state.resp;
  assign tx_valid   = state.tx_valid;
  assign tx_req     = state.tx;
  assign baud_sel   = state.active.baud_rate; // [RULE_09]
  assign prdata     = state.prdata;
  assign pready     = state.pready;
  assign pslverr    = state.pslverr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_good_at;
    frame_ok && is_at;
  endsequence
  sequence s_queued_baud;
    s_good_at ##0 (state.ftype == `TYPE_AT_QUEUED && state.has_val && state.cmd == `CMD_BAUD_RATE);
  endsequence
  sequence s_apply_baud;
    s_good_at ##0 ((state.cmd == `CMD_APPLY || state.ftype == `TYPE_AT_NOW) && state.pend[0]
                   && !(state.has_val && state.cmd == `CMD_BAUD_RATE));
  endsequence

  a_hunt_delim: assert property (state.phase == PH_HUNT && rx_take && rx_data != `START_DELIM // [RULE_01]
    |=> state.phase == PH_HUNT) else $error("non-delimiter byte left hunt");
  a_resp_good_frame: assert property (resp_valid |-> $past(frame_ok)) // [RULE_02]
    else $error("reply without a good checksum");
  a_resp_id_nonzero: assert property (resp_valid |-> resp.frame_id != `FRAME_ID_NONE) // [RULE_04]
    else $error("reply sent for zero frame id");
  a_query_reply: assert property (s_good_at ##0 (!state.has_val && state.fid != `FRAME_ID_NONE) // [RULE_08]
    |=> resp_valid && resp.frame_type == `TYPE_AT_RESP && resp.frame_id == $past(state.fid))
    else $error("query reply missing or wrong");
  a_queue_holds: assert property (s_queued_baud |=> $stable(baud_sel)[*3]) // [RULE_09]
    else $error("queued baud took effect");
  a_apply_commits: assert property (s_apply_baud |=> baud_sel == $past(state.staged.baud_rate)) // [RULE_07]
    else $error("apply did not commit staged baud");
  a_immediate_set: assert property (s_good_at ##0 (state.ftype == `TYPE_AT_NOW && state.has_val // [RULE_17]
    && state.cmd == `CMD_BAUD_RATE) |=> baud_sel == $past(state.val)) else $error("immediate set lost");
  a_tx_status: assert property (frame_ok && is_tx && state.fid != `FRAME_ID_NONE // [RULE_10]
    |=> tx_valid && resp_valid && resp.frame_type == `TYPE_TX_STATUS) else $error("no transmit status");
  a_radius_default: assert property (frame_ok && is_tx && state.radius == `USE_DEFAULT // [RULE_14]
    |=> tx_req.radius == $past(state.active.max_hops)) else $error("radius default not used");
  a_options_default: assert property (frame_ok && is_tx && state.opts == `USE_DEFAULT // [RULE_15]
    |=> tx_req.options == $past(state.active.tx_options)) else $error("options default not used");
  a_bad_no_output: assert property (frame_end && !frame_ok |=> !resp_valid && !tx_valid) // [RULE_18]
    else $error("bad frame produced output");

endmodule : api_request_frame_decoder

/* File: sim/host_source.sv */
// host model: sends queued frame bytes over the valid/ready byte port
`timescale 1ns/10ps
module host_source (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       rx_ready,
  output logic            rx_valid,
  output logic [7:0]      rx_data
);
  logic [7:0] q[$];
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // a byte stands until taken; idle data toggles so nothing stale looks valid
  always @(posedge clock) begin
    if (rx_valid && rx_ready) begin
      void'(q.pop_front());
    end
    if (q.size() != 0 && !rst) begin
      rx_valid <= 1'b1;
      rx_data  <= q[0];
    end else begin
      rx_valid <= 1'b0;
      rx_data  <= ~rx_data;
    end
  end
endmodule : host_source

/* File: sim/tb_api_request_frame_decoder.sv */
// self-checking bench for the request frame decoder
`timescale 1ns/10ps
module tb_api_request_frame_decoder;
  import frame_pkg::*;
  logic           clock = 1'b0;
  logic           rst = 1'b1;
  logic           rx_valid, rx_ready, resp_valid, tx_valid, pay_valid, psel, penable, pwrite, pready, pslverr, err;
  logic           pay_ready = 1'b1;
  logic [7:0]     rx_data, pay_data, baud_sel, paddr;
  logic [31:0]    pwdata, prdata, rd;
  response_type   resp, last_resp;
  tx_request_type tx_req, last_tx;
  logic [7:0]     pay_q[$];
  int             n_fail = 0, comparisons = 0, n_resp = 0, n;
  always #50 clock = ~clock;
  host_source host (.clock, .rst, .rx_ready, .rx_valid, .rx_data);
  api_request_frame_decoder uut (.clock, .rst, .rx_data, .rx_valid, .rx_ready, .resp_valid, .resp, .tx_valid,
    .tx_req, .pay_data, .pay_valid, .pay_ready, .baud_sel, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  always @(posedge clock) begin
    if (resp_valid === 1'b1) begin
      n_resp++;
      last_resp = resp;
    end
    if (tx_valid === 1'b1) last_tx = tx_req;
    if (pay_valid === 1'b1 && pay_ready) pay_q.push_back(pay_data);
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clock);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin n_fail++; close_out(); end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // let an edge pass so a following call never reassigns psel in this step
    @(posedge clock);
  endtask : apb
  task automatic frame(input logic [7:0] b[$], input logic [7:0] spoil);
    logic [7:0] s;
    int i;
    s = 8'h00;
    foreach (b[k]) s += b[k];
    host.q.push_back(8'h7E);
    host.q.push_back(8'h00);
    host.q.push_back(8'(b.size()));
    foreach (b[k]) host.q.push_back(b[k]);
    host.q.push_back((8'hFF - s) ^ spoil);
    for (i = 0; i < 300 && host.q.size() != 0; i++) @(posedge clock);
    if (i == 300) begin n_fail++; close_out(); end
    repeat (6) @(posedge clock);
  endtask : frame
  initial begin
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    check({rx_ready, resp_valid, tx_valid, pay_valid, pready, baud_sel}, {5'b10000, 8'h03});
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00000703);
    apb(1'b0, 8'h14, 32'h0);
    check(err, 1'b1);
    $display("test reset and registers done");
    frame('{8'h09, 8'h17, 8'h4E, 8'h48}, 8'h00);
    check(last_resp, {8'h88, 8'h17, 16'h4E48, 8'h07});
    frame('{8'h09, 8'h53, 8'h42, 8'h44, 8'h07}, 8'h00);
    check(baud_sel, 8'h03);
    check(last_resp, {8'h88, 8'h53, 16'h4244, 8'h00});
    n = n_resp;
    frame('{8'h09, 8'h00, 8'h41, 8'h43}, 8'h00);
    check(n_resp, n);
    check(baud_sel, 8'h07);
    frame('{8'h08, 8'h21, 8'h54, 8'h4F, 8'h01}, 8'h00);
    apb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h00010707);
    $display("test staged and immediate settings done");
    apb(1'b1, 8'h10, 32'h0);
    n = n_resp;
    frame('{8'h09, 8'h17, 8'h4E, 8'h48}, 8'h01);
    check(n_resp, n);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h00000001);
    $display("test bad checksum done");
    // broadcast pattern, short address unknown, radius and options left to defaults
    frame('{8'h10, 8'h8D, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFE,
            8'h00, 8'h00, 8'h5A, 8'hA5}, 8'h00);
    check(last_tx.dest64, 64'h000000000000FFFF);
    check({last_tx.dest16, last_tx.radius, last_tx.options}, 32'hFFFE0701);
    check({last_resp.frame_type, last_resp.frame_id}, 16'h8B8D);
    check({pay_q.size() == 2, pay_q[0], pay_q[1]}, {1'b1, 16'h5AA5});
    // short addressing: all-ones 64-bit field, known short address, explicit options, no reply wanted
    n = n_resp;
    frame('{8'h10, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h12, 8'h34,
            8'h00, 8'h02, 8'hC3}, 8'h00);
    check(last_tx.dest64, 64'hFFFFFFFFFFFFFFFF);
    check({last_tx.dest16, last_tx.radius, last_tx.options}, 32'h12340702);
    check(n_resp, n);
    check({pay_q.size() == 3, pay_q[2]}, {1'b1, 8'hC3});
    // payload longer than the maximum is dropped and counted
    apb(1'b1, 8'h0C, 32'h00000001);
    frame('{8'h10, 8'h44, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h12, 8'h34,
            8'h00, 8'h00, 8'h5A, 8'hA5}, 8'h00);
    apb(1'b0, 8'h10, 32'h0);
    check({n_resp == n, pay_q.size() == 3, rd}, {2'b11, 32'h00000002});
    $display("test transmit request done");
    close_out();
  end
endmodule : tb_api_request_frame_decoder
